// ===== common/tpl_pkg.sv
// package for the three-point position latch
// assumes a single 100 MHz clock domain and an APB register bus
package tpl_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_FWD_WIN   = 8'h00;
  localparam logic [7:0] ADDR_REV_WIN   = 8'h04;
  localparam logic [7:0] ADDR_OPT1_SEL  = 8'h08;
  localparam logic [7:0] ADDR_OPT2_SEL  = 8'h0C;
  localparam logic [7:0] ADDR_CTRL      = 8'h10;
  localparam logic [7:0] ADDR_IO        = 8'h14;
  localparam logic [7:0] ADDR_IO_STAT   = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h20;
  localparam logic [7:0] ADDR_POS       = 8'h24;
  localparam logic [7:0] ADDR_VIEW1     = 8'h28;
  localparam logic [7:0] ADDR_VIEW2     = 8'h2C;
  localparam logic [7:0] ADDR_VIEW3     = 8'h30;
  localparam logic [7:0] ADDR_CMD       = 8'h34;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_WIN  = 32'h0000_0000;
  localparam logic [15:0] RST_OSEL = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ---------------------------------------------------------------
  // io field positions
  // ---------------------------------------------------------------
  localparam int IO_REQ_LSB = 28;
  localparam int NUM_POINTS = 3;

  // ---------------------------------------------------------------
  // option view selector codes
  // ---------------------------------------------------------------
  localparam logic [15:0] OSEL_POS_C = 16'h0034;
  localparam logic [15:0] OSEL_POS_D = 16'h0036;

  // ---------------------------------------------------------------
  // monitor slot codes
  // ---------------------------------------------------------------
  localparam logic [3:0] MON_FB_POS  = 4'h0;
  localparam logic [3:0] MON_POS_B   = 4'h4;
  localparam logic [3:0] MON_OPT_ONE = 4'hE;
  localparam logic [3:0] MON_OPT_TWO = 4'hF;

  // capturing command code (the one that owns auxiliary latch bits)
  localparam logic [7:0] CMD_CAPTURE_OWNER = 8'h01;

  // ---------------------------------------------------------------
  // command control field layout
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] rsv_31_28;
    logic [3:0] view_select_three;  // 27:24
    logic [3:0] view_select_two;    // 23:20
    logic [3:0] view_select_one;    // 19:16
    logic [3:0] rsv_15_12;
    logic [1:0] capture_source_select; // 11:10
    logic       rsv_9;
    logic       single_capture_request; // 8
    logic [1:0] rsv_7_6;
    logic [1:0] reference_filter_select; // 5:4
    logic [1:0] halt_style;         // 3:2
    logic       cancel;             // 1
    logic       pause;              // 0
  } tpl_ctrl_s;

  // decoded control outputs, auxiliary bits gated by command
  typedef struct packed {
    logic       pause;
    logic       cancel;
    logic [1:0] halt_style;
    logic [1:0] filter_sel;
    logic       single_req;
    logic [1:0] source_sel;
  } tpl_dec_s;

endpackage

// ===== rtl/tpl_window.sv
// latching window check for one position sample
// assumes signed 32-bit positions in reference units
module tpl_window (
  input  wire logic signed [31:0] fwd_in,   // forward limit
  input  wire logic signed [31:0] rev_in,   // reverse limit
  input  wire logic signed [31:0] pos_in,   // current position
  output logic                    inside_out // position may latch
);
  // open window when limits are not ordered
  always_comb begin
    if (fwd_in > rev_in) begin
      inside_out = (pos_in >= rev_in) && (pos_in <= fwd_in);
    end else begin
      inside_out = 1'b1;
    end
  end
endmodule

// ===== rtl/tpl_channel.sv
// one latch channel: arm, gate, capture, done flag
// assumes edge input already synchronous to clk
module tpl_channel (
  input  wire logic        clk_in,      // clock
  input  wire logic        arst_n_in,   // async reset, low
  input  wire logic        req_in,      // capture request level
  input  wire logic        win_in,      // inside window
  input  wire logic        ext_n_in,    // latch input, active low
  input  wire logic [31:0] pos_in,      // current position
  output logic             done_out,    // captured flag
  output logic             event_out,   // capture pulse
  output logic [31:0]      cap_out      // captured position
);
  logic ext_d_reg;
  logic edge_w;

  assign edge_w    = ext_d_reg & ~ext_n_in;
  // capture only while requested and in window, once per request
  assign event_out = req_in & win_in & edge_w & ~done_out;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ext_d_reg <= 1'b1;
    end else begin
      ext_d_reg <= ext_n_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      done_out <= 1'b0;
    end else if (!req_in) begin
      done_out <= 1'b0;
    end else if (event_out) begin
      done_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cap_out <= 32'h0000_0000;
    end else if (event_out) begin
      cap_out <= pos_in;
    end
  end
endmodule

// ===== rtl/tpl_latch_top.sv
// three-point position latch with apb registers
// assumes APB master on CLK_IN and synchronous latch inputs
// Operation
// - option view one picks c or d
// - option view two picks c or d
// - signed window limits, reset zero
// - accept edge only windowed and requested
// - gating applies under every command
// - done flags at io bits 28-30
// - channel one fills b, monitor code 4
// - channel two fills c, codes E/F
// - channel three fills d, codes E/F
// - control field in frame bytes 4-7
// - auxiliary bits only for owning command
// - control honoured during command alarm
// - control field bit layout decode
// - request rise arms, input ends latch
// - request low cancels pending latch
module tpl_latch_top (
  input  wire logic        CLK_IN,         // 100 MHz clock
  input  wire logic        ARST_N_IN,      // async reset, low
  input  wire logic        PSEL_IN,        // apb select
  input  wire logic        PENABLE_IN,     // apb enable
  input  wire logic        PWRITE_IN,      // apb write
  input  wire logic [7:0]  PADDR_IN,       // apb address
  input  wire logic [31:0] PWDATA_IN,      // apb write data
  output logic [31:0]      PRDATA_OUT,     // apb read data
  output logic             PREADY_OUT,     // apb ready
  output logic             PSLVERR_OUT,    // apb error
  input  wire logic [31:0] POSITION_IN,    // feedback position
  input  wire logic [2:0]  EXT_N_IN,       // latch inputs, low
  input  wire logic        COMMAND_ALARM_IN, // command alarm
  output logic [31:0]      VIEW_ONE_OUT,   // monitor slot one
  output logic [31:0]      VIEW_TWO_OUT,   // monitor slot two
  output logic [31:0]      VIEW_THREE_OUT, // monitor slot three
  output logic [2:0]       DONE_OUT,       // capture done flags
  output logic [9:0]       CTRL_DEC_OUT,   // decoded control
  output logic             IRQ_OUT         // interrupt level
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  localparam int NUM_CH = tpl_pkg::NUM_POINTS;

  logic [31:0]       fwd_win_reg;
  logic [31:0]       rev_win_reg;
  logic [15:0]       opt1_sel_reg;
  logic [15:0]       opt2_sel_reg;
  logic [31:0]       ctrl_reg;
  logic [31:0]       io_reg;
  logic [7:0]        cmd_reg;
  logic [2:0]        irq_stat_reg;
  logic [2:0]        irq_mask_reg;
  logic [31:0]       rdata_next;
  logic              wr_w;
  logic              rd_w;
  logic              inside_w;
  logic [2:0]        req_w;
  logic [2:0]        event_w;
  logic [31:0]       cap_w [NUM_CH];
  logic [31:0]       opt_one_w;
  logic [31:0]       opt_two_w;
  tpl_pkg::tpl_ctrl_s ctrl_w;
  tpl_pkg::tpl_dec_s  dec_w;

  assign wr_w = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign rd_w = PSEL_IN & PENABLE_IN & ~PWRITE_IN;

  // ---------------------------------------------------------------
  // apb write side
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      fwd_win_reg <= tpl_pkg::RST_WIN;
      rev_win_reg <= tpl_pkg::RST_WIN;
    end else if (wr_w) begin
      if (PADDR_IN == tpl_pkg::ADDR_FWD_WIN) begin
        fwd_win_reg <= PWDATA_IN;
      end
      if (PADDR_IN == tpl_pkg::ADDR_REV_WIN) begin
        rev_win_reg <= PWDATA_IN;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      opt1_sel_reg <= tpl_pkg::RST_OSEL;
      opt2_sel_reg <= tpl_pkg::RST_OSEL;
    end else if (wr_w) begin
      if (PADDR_IN == tpl_pkg::ADDR_OPT1_SEL) begin
        opt1_sel_reg <= PWDATA_IN[15:0];
      end
      if (PADDR_IN == tpl_pkg::ADDR_OPT2_SEL) begin
        opt2_sel_reg <= PWDATA_IN[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // command frame fields
  // ---------------------------------------------------------------
  // control is bytes 4-7, stored little endian
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ctrl_reg <= tpl_pkg::RST_WORD;
      io_reg   <= tpl_pkg::RST_WORD;
      cmd_reg  <= 8'h00;
    end else if (wr_w) begin
      if (PADDR_IN == tpl_pkg::ADDR_CTRL) begin
        ctrl_reg <= PWDATA_IN;
      end
      if (PADDR_IN == tpl_pkg::ADDR_IO) begin
        io_reg <= PWDATA_IN;
      end
      if (PADDR_IN == tpl_pkg::ADDR_CMD) begin
        cmd_reg <= PWDATA_IN[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      irq_mask_reg <= 3'h0;
    end else if (wr_w && PADDR_IN == tpl_pkg::ADDR_IRQ_MASK) begin
      irq_mask_reg <= PWDATA_IN[2:0];
    end
  end

  // sticky events, set wins over write-one-to-clear
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      irq_stat_reg <= 3'h0;
    end else begin
      if (wr_w && PADDR_IN == tpl_pkg::ADDR_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~PWDATA_IN[2:0]) | event_w;
      end else begin
        irq_stat_reg <= irq_stat_reg | event_w;
      end
    end
  end

  // level output, any unmasked status bit
  assign IRQ_OUT = |(irq_stat_reg & irq_mask_reg);

  // ---------------------------------------------------------------
  // control field decode
  // ---------------------------------------------------------------
  // alarm input deliberately not used to gate decode
  assign ctrl_w = tpl_pkg::tpl_ctrl_s'(ctrl_reg);

  always_comb begin
    dec_w.pause      = ctrl_w.pause;
    dec_w.cancel     = ctrl_w.cancel;
    dec_w.halt_style = ctrl_w.halt_style;
    dec_w.filter_sel = ctrl_w.reference_filter_select;
    dec_w.single_req = 1'b0;
    dec_w.source_sel = 2'h0;
    if (cmd_reg == tpl_pkg::CMD_CAPTURE_OWNER) begin
      dec_w.single_req = ctrl_w.single_capture_request;
      dec_w.source_sel = ctrl_w.capture_source_select;
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      CTRL_DEC_OUT <= 10'h000;
    end else begin
      // pad bit above the decoded fields
      CTRL_DEC_OUT <= {1'b0, dec_w};
    end
  end

  // ---------------------------------------------------------------
  // latch channels
  // ---------------------------------------------------------------
  tpl_window u_window (
    .fwd_in     (fwd_win_reg),
    .rev_in     (rev_win_reg),
    .pos_in     (POSITION_IN),
    .inside_out (inside_w)
  );

  // request bits gate every channel regardless of command
  assign req_w = io_reg[tpl_pkg::IO_REQ_LSB +: NUM_CH];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      tpl_channel u_ch (
        .clk_in    (CLK_IN),
        .arst_n_in (ARST_N_IN),
        .req_in    (req_w[gi]),
        .win_in    (inside_w),
        .ext_n_in  (EXT_N_IN[gi]),
        .pos_in    (POSITION_IN),
        .done_out  (DONE_OUT[gi]),
        .event_out (event_w[gi]),
        .cap_out   (cap_w[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // monitor routing
  // ---------------------------------------------------------------
  function automatic logic [31:0] opt_pick(input logic [15:0] sel,
                                           input logic [31:0] pc,
                                           input logic [31:0] pd);
    if (sel == tpl_pkg::OSEL_POS_C) begin
      return pc;
    end else if (sel == tpl_pkg::OSEL_POS_D) begin
      return pd;
    end
    return 32'h0000_0000;
  endfunction

  // immediate: combinational on selector
  assign opt_one_w = opt_pick(opt1_sel_reg, cap_w[1], cap_w[2]);
  assign opt_two_w = opt_pick(opt2_sel_reg, cap_w[1], cap_w[2]);

  function automatic logic [31:0] mon_pick(input logic [3:0] code,
                                           input logic [31:0] fb,
                                           input logic [31:0] pb,
                                           input logic [31:0] o1,
                                           input logic [31:0] o2);
    case (code)
      tpl_pkg::MON_FB_POS:  return fb;
      tpl_pkg::MON_POS_B:   return pb;
      tpl_pkg::MON_OPT_ONE: return o1;
      tpl_pkg::MON_OPT_TWO: return o2;
      default:              return 32'h0000_0000;
    endcase
  endfunction

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      VIEW_ONE_OUT   <= 32'h0000_0000;
      VIEW_TWO_OUT   <= 32'h0000_0000;
      VIEW_THREE_OUT <= 32'h0000_0000;
    end else begin
      VIEW_ONE_OUT   <= mon_pick(ctrl_w.view_select_one, POSITION_IN,
                                 cap_w[0], opt_one_w, opt_two_w);
      VIEW_TWO_OUT   <= mon_pick(ctrl_w.view_select_two, POSITION_IN,
                                 cap_w[0], opt_one_w, opt_two_w);
      VIEW_THREE_OUT <= mon_pick(ctrl_w.view_select_three, POSITION_IN,
                                 cap_w[0], opt_one_w, opt_two_w);
    end
  end

  // ---------------------------------------------------------------
  // apb read side
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (PADDR_IN)
      tpl_pkg::ADDR_FWD_WIN:  rdata_next = fwd_win_reg;
      tpl_pkg::ADDR_REV_WIN:  rdata_next = rev_win_reg;
      tpl_pkg::ADDR_OPT1_SEL: rdata_next = {16'h0000, opt1_sel_reg};
      tpl_pkg::ADDR_OPT2_SEL: rdata_next = {16'h0000, opt2_sel_reg};
      tpl_pkg::ADDR_CTRL:     rdata_next = ctrl_reg;
      tpl_pkg::ADDR_IO:       rdata_next = io_reg;
      tpl_pkg::ADDR_IO_STAT:  rdata_next = {1'b0, DONE_OUT, 28'h000_0000};
      tpl_pkg::ADDR_IRQ_STAT: rdata_next = {29'h0000_0000, irq_stat_reg};
      tpl_pkg::ADDR_IRQ_MASK: rdata_next = {29'h0000_0000, irq_mask_reg};
      tpl_pkg::ADDR_POS:      rdata_next = POSITION_IN;
      tpl_pkg::ADDR_VIEW1:    rdata_next = VIEW_ONE_OUT;
      tpl_pkg::ADDR_VIEW2:    rdata_next = VIEW_TWO_OUT;
      tpl_pkg::ADDR_VIEW3:    rdata_next = VIEW_THREE_OUT;
      tpl_pkg::ADDR_CMD:      rdata_next = {24'h00_0000, cmd_reg};
      default:                rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
      PRDATA_OUT <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // apb response
  // ---------------------------------------------------------------
  // word aligned and inside the map
  function automatic logic addr_ok(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= tpl_pkg::ADDR_CMD);
  endfunction

  // zero wait states, every access completes
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_ok(PADDR_IN);

  logic unused_w;
  assign unused_w = COMMAND_ALARM_IN & rd_w;

endmodule

// ===== testbench/tpl_latch_monitor.sv
// checker for the three-point position latch top
// assumes apb writes take effect on the access edge
module tpl_latch_monitor (
  input wire logic        CLK_IN,       // clock
  input wire logic        ARST_N_IN,    // reset, low
  input wire logic        PSEL_IN,      // select
  input wire logic        PENABLE_IN,   // enable
  input wire logic        PWRITE_IN,    // write
  input wire logic [7:0]  PADDR_IN,     // address
  input wire logic [31:0] PWDATA_IN,    // write data
  input wire logic        PSLVERR_OUT,  // error
  input wire logic [31:0] POSITION_IN,  // position
  input wire logic [2:0]  EXT_N_IN,     // latch inputs
  input wire logic [31:0] VIEW_ONE_OUT, // slot one
  input wire logic [2:0]  DONE_OUT,     // done flags
  input wire logic [9:0]  CTRL_DEC_OUT, // decode
  input wire logic        IRQ_OUT       // interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        [31:0] ctrl_q;
  logic        [31:0] io_q;
  logic signed [31:0] fwd_q;
  logic signed [31:0] rev_q;
  logic        [7:0]  cmd_q;
  logic        [2:0]  msk_q;
  logic               in_win;
  logic        [8:0]  exp_dec;
  // ---------------------------------------------------------------
  // shadow of written registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ctrl_q <= 32'h0000_0000;
      io_q   <= 32'h0000_0000;
      fwd_q  <= tpl_pkg::RST_WIN;
      rev_q  <= tpl_pkg::RST_WIN;
      cmd_q  <= 8'h00;
      msk_q  <= 3'h0;
    end else if (PSEL_IN && PENABLE_IN && PWRITE_IN) begin
      case (PADDR_IN)
        tpl_pkg::ADDR_CTRL:     ctrl_q <= PWDATA_IN;
        tpl_pkg::ADDR_IO:       io_q   <= PWDATA_IN;
        tpl_pkg::ADDR_FWD_WIN:  fwd_q  <= PWDATA_IN;
        tpl_pkg::ADDR_REV_WIN:  rev_q  <= PWDATA_IN;
        tpl_pkg::ADDR_CMD:      cmd_q  <= PWDATA_IN[7:0];
        tpl_pkg::ADDR_IRQ_MASK: msk_q  <= PWDATA_IN[2:0];
        default: ;
      endcase
    end
  end
  assign in_win = (fwd_q > rev_q) ? ($signed(POSITION_IN) >= rev_q &&
                  $signed(POSITION_IN) <= fwd_q) : 1'b1;
  assign exp_dec = {ctrl_q[0], ctrl_q[1], ctrl_q[3:2], ctrl_q[5:4],
                    (cmd_q == tpl_pkg::CMD_CAPTURE_OWNER) ?
                    {ctrl_q[8], ctrl_q[11:10]} : 3'h0};
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  done_edge_a: assert property ($rose(DONE_OUT[0]) |->
    !$past(EXT_N_IN[0]) && $past(EXT_N_IN[0], 2) && $past(io_q[28]))
    else $error("done without requested falling edge");
  win_gate_a: assert property ($rose(DONE_OUT[1]) |->
    $past(in_win) && $past(io_q[29]))
    else $error("capture outside window or unrequested");
  req_cancel_a: assert property ($fell(io_q[30]) |=>
    !DONE_OUT[2]) else $error("done kept after request drop");
  done_hold_a: assert property (DONE_OUT[0] && io_q[28] |=>
    DONE_OUT[0]) else $error("done flag lost");
  view_pos_a: assert property (ctrl_q[19:16] == 4'h0 |=>
    VIEW_ONE_OUT == $past(POSITION_IN)) else $error("slot not position");
  view_rsv_a: assert property (ctrl_q[19:16] == 4'h1 |=>
    VIEW_ONE_OUT == 32'h0000_0000) else $error("unused code not zero");
  irq_rise_a: assert property ($rose(DONE_OUT[0]) && msk_q[0]
    |-> IRQ_OUT) else $error("interrupt missing on capture");
  apb_err_a: assert property (PSEL_IN && PENABLE_IN |->
    PSLVERR_OUT == (PADDR_IN[1:0] != 2'h0 || PADDR_IN > tpl_pkg::ADDR_CMD))
    else $error("error response wrong");
  ctrl_dec_a: assert property (1'b1 |=>
    CTRL_DEC_OUT[8:0] == $past(exp_dec)) else $error("decode mismatch");
endmodule
bind tpl_latch_top tpl_latch_monitor mon_u (
  .CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PSLVERR_OUT(PSLVERR_OUT),
  .POSITION_IN(POSITION_IN), .EXT_N_IN(EXT_N_IN),
  .VIEW_ONE_OUT(VIEW_ONE_OUT), .DONE_OUT(DONE_OUT),
  .CTRL_DEC_OUT(CTRL_DEC_OUT), .IRQ_OUT(IRQ_OUT));

// ===== testbench/tpl_motion_model.sv
// motion side model: feedback position and latch inputs
// assumes the bench calls its tasks right after a clock edge
module tpl_motion_model (
  input  wire logic        clk_in,    // clock
  output logic      [31:0] pos_out,   // feedback position
  output logic      [2:0]  ext_n_out  // latch inputs, low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pos_out = 32'h0000_0000;
    ext_n_out = 3'h7;
  end
  task automatic move(input logic [31:0] p);
    @(posedge clk_in);
    pos_out <= p;
  endtask
  // low for two cycles, then back to the pulled-up idle level
  task automatic strike(input int ch);
    @(posedge clk_in);
    ext_n_out[ch] <= 1'b0;
    repeat (2) @(posedge clk_in);
    ext_n_out[ch] <= 1'b1;
  endtask
endmodule

// ===== testbench/tpl_latch_tb_top.sv
// bench for the three-point position latch
// assumes zero-wait apb slave and registered done flags
module tpl_latch_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, psel, pen, pwr, pready, pslverr, alarm, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, pos, v1, v2, v3;
  logic [2:0]  ext_n, done;
  logic [9:0]  dec;
  int          miscompares;
  int          n_tests;
  tpl_latch_top dut_u (.CLK_IN(clk), .ARST_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .POSITION_IN(pos), .EXT_N_IN(ext_n),
    .COMMAND_ALARM_IN(alarm), .VIEW_ONE_OUT(v1), .VIEW_TWO_OUT(v2),
    .VIEW_THREE_OUT(v3), .DONE_OUT(done), .CTRL_DEC_OUT(dec),
    .IRQ_OUT(irq));
  tpl_motion_model mdl_u (.clk_in(clk), .pos_out(pos), .ext_n_out(ext_n));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    n = 0;
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) miscompares++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, x);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic hit(input logic [31:0] p, input int ch);
    mdl_u.move(p);
    mdl_u.strike(ch);
    wt(2);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rd(tpl_pkg::ADDR_FWD_WIN, tpl_pkg::RST_WIN);
    rd(tpl_pkg::ADDR_REV_WIN, tpl_pkg::RST_WIN);
    wr(tpl_pkg::ADDR_FWD_WIN, 32'h7FFF_FFFF);
    wr(tpl_pkg::ADDR_REV_WIN, 32'h8000_0000);
    rd(tpl_pkg::ADDR_FWD_WIN, 32'h7FFF_FFFF);
    rd(tpl_pkg::ADDR_REV_WIN, 32'h8000_0000);
    apb(1'b0, 8'h3C, 32'h0000_0000, r, e);
    chk({r[31:1], e}, 32'h0000_0001);
    chk(32'(pready), 32'h0000_0001);
    $display("test regs done");
  endtask
  task automatic t_window();
    wr(tpl_pkg::ADDR_FWD_WIN, 32'h0000_0064);
    wr(tpl_pkg::ADDR_REV_WIN, 32'hFFFF_FF9C);
    wr(tpl_pkg::ADDR_IO, 32'h1000_0000);
    hit(32'h0000_01F4, 0);
    chk(32'(done), 32'h0000_0000);
    hit(32'hFFFF_FF9C, 0);
    chk(32'(done), 32'h0000_0001);
    rd(tpl_pkg::ADDR_IO_STAT, 32'h1000_0000);
    wr(tpl_pkg::ADDR_CTRL, 32'h0004_0000);
    hit(32'h0000_0007, 0);
    chk(v1, 32'hFFFF_FF9C);
    wr(tpl_pkg::ADDR_FWD_WIN, 32'h0000_0005);
    wr(tpl_pkg::ADDR_REV_WIN, 32'h0000_0005);
    wr(tpl_pkg::ADDR_IO, 32'h3000_0000);
    hit(32'h0001_0000, 1);
    chk(32'(done), 32'h0000_0003);
    $display("test window done");
  endtask
  task automatic t_cancel();
    hit(32'h0000_0033, 2);
    chk(32'(done), 32'h0000_0003);
    wr(tpl_pkg::ADDR_IO, 32'h7000_0000);
    hit(32'h0000_0033, 2);
    chk(32'(done), 32'h0000_0007);
    wr(tpl_pkg::ADDR_IO, 32'h0000_0000);
    wt(2);
    chk(32'(done), 32'h0000_0000);
    wr(tpl_pkg::ADDR_IO, 32'h4000_0000);
    hit(32'h0000_0044, 2);
    chk(32'(done), 32'h0000_0004);
    $display("test cancel done");
  endtask
  task automatic t_views();
    wr(tpl_pkg::ADDR_CTRL, 32'h00FE_0000);
    wr(tpl_pkg::ADDR_OPT1_SEL, {16'h0000, tpl_pkg::OSEL_POS_C});
    wr(tpl_pkg::ADDR_OPT2_SEL, {16'h0000, tpl_pkg::OSEL_POS_D});
    wt(2);
    chk(v1, 32'h0001_0000);
    chk(v2, 32'h0000_0044);
    chk(v3, 32'h0000_0044);
    wr(tpl_pkg::ADDR_OPT1_SEL, {16'h0000, tpl_pkg::OSEL_POS_D});
    wr(tpl_pkg::ADDR_OPT2_SEL, {16'h0000, tpl_pkg::OSEL_POS_C});
    wt(2);
    chk(v1, 32'h0000_0044);
    chk(v2, 32'h0001_0000);
    wr(tpl_pkg::ADDR_OPT1_SEL, 32'h0000_0035);
    wt(2);
    chk(v1, 32'h0000_0000);
    $display("test views done");
  endtask
  task automatic t_irq();
    chk(32'(irq), 32'h0000_0000);
    wr(tpl_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
    wt(1);
    chk(32'(irq), 32'h0000_0001);
    rd(tpl_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
    wr(tpl_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
    wt(1);
    chk(32'(irq), 32'h0000_0000);
    wr(tpl_pkg::ADDR_IO, 32'h1000_0000);
    hit(32'h0000_0001, 0);
    chk(32'(irq), 32'h0000_0001);
    rd(tpl_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
    $display("test irq done");
  endtask
  task automatic t_ctrl();
    logic [1:0] k;
    logic       own;
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      own = k[0];
      wr(tpl_pkg::ADDR_CMD, own ? 32'h0000_0001 : 32'h0000_0002);
      alarm <= k[1];
      wr(tpl_pkg::ADDR_CTRL, {16'h0001, 6'h03, 2'h1, 2'h0, ~k, k, k});
      wt(2);
      chk(32'(dec[8:0]),
          32'({k[0], k[1], k, ~k, own ? 3'h7 : 3'h0}));
      chk(32'(dec[9]), 32'h0000_0000);
      chk(v1, 32'h0000_0000);
    end
    $display("test ctrl done");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; alarm = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000;
    miscompares = 0; n_tests = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_window();
    t_cancel();
    t_views();
    t_irq();
    t_ctrl();
    conclude();
  end
  initial begin
    #200_000;
    miscompares++;
    conclude();
  end
endmodule
